// ### pkg/otpsc_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit register space behind a two-wire serial port
// Notes:   Definitions only
`ifndef OTPSC_DEFS_SVH
`define OTPSC_DEFS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OTPSC_REG_ECC      8'h0e
`define OTPSC_REG_PAGE     8'h7f
`define OTPSC_REG_PREP_A   8'hd0
`define OTPSC_REG_PREP_B   8'hd8
`define OTPSC_REG_BURN     8'hd9
`define OTPSC_REG_INCFG    8'he0
`define OTPSC_REG_TRY      8'he4
`define OTPSC_REG_RSTCFG   8'he8
`define OTPSC_REG_BUSADDR  8'hff
`define OTPSC_SHADOW_BASE  8'ha0
// ----------------------------------------------------------------
// Page and key values
// ----------------------------------------------------------------
`define OTPSC_PAGE_MAIN    8'h00
`define OTPSC_PAGE_SHADOW  8'h01
`define OTPSC_PAGE_PROG    8'h02
`define OTPSC_PREP_A_KEY   8'hff
`define OTPSC_PREP_B_KEY   8'h46
`define OTPSC_BURN_KEY     8'hff
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define OTPSC_TRY_BIT      7
`define OTPSC_ECC_BIT      0
`define OTPSC_PGEN_BIT     0
`define OTPSC_POWER_ON_PIN_BIT    0
`define OTPSC_DVS_BIT      1
`define OTPSC_SEQCLK_BIT   2
`define OTPSC_ADDR_HIGH    4'h1
`define OTPSC_ROM_BUSADDR  8'h08
`define OTPSC_SHADOW_RESET 8'h00
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OTPSC_MCLK_NS      4
`define OTPSC_RST_REL_NS   2000000
`endif

// ### pkg/otpsc_pkg.sv
// Purpose: State types of the start-up configuration loader
// Assumes: One-hot state codes
// Notes:   Constants live in otpsc_defs.svh
package otpsc_pkg;
	typedef enum logic [6:0] {
		otpsc_i_idle = 7'h01,
		otpsc_i_addr = 7'h02,
		otpsc_i_acka = 7'h04,
		otpsc_i_rx   = 7'h08,
		otpsc_i_ackw = 7'h10,
		otpsc_i_tx   = 7'h20,
		otpsc_i_ackr = 7'h40
	} otpsc_i2c_t;
	typedef enum logic [4:0] {
		otpsc_l_pick = 5'h01,
		otpsc_l_fuse = 5'h02,
		otpsc_l_off  = 5'h04,
		otpsc_l_on   = 5'h08,
		otpsc_l_burn = 5'h10
	} otpsc_ld_t;
endpackage

// ### hdl/otpsc_loader.sv
// Purpose: Shadow configuration loader, fuse burn and serial register port
// Assumes: i_rst_n follows the first valid main input supply
// Notes:   Fuse macro reads asynchronously from o_fuse_bank
`timescale 1ns/100ps
`include "otpsc_defs.svh"
// Behaviour
// - Shadow registers clear to zero when main supply first becomes valid.
// - Programming pin at core rail loads shadow registers from default ROM.
// - Pin at 0 V with try-mode bit set keeps present shadow contents.
// - Pin at 0 V with try-mode bit clear loads shadow from fuses.
// - Try-mode power-up bit is zero after reset.
// - Serial access works only with main and I/O supplies valid.
// - Shadow contents are kept while any supply keeps the block alive.
// - Turn-on uses shadow only with valid supply, 0 V pin, try bit set.
// - Shadow registers live in page 1, selected by 01 at 7F.
// - Five fuse banks of 26: twenty data bits, six check bits.
// - Single-bit fuse errors in a bank are corrected on read.
// - Writing FF to D9 on page 2 burns fuses from shadow contents.
// - Power-on pin low then high reloads fuses into shadow with 0 V pin, try bit clear.
// - Corrections set the ECC bit in 0E; master rejects on it.
// - Bus address is bit 3 set, low three bits from FF.
// - Power-good enable clear: reset out releases 2.0 ms after sequence.
// - E0 at zero: level power-on, slow voltage step, 500 us sequencing.
// - Writing 80 to E4 sets the try-mode power-up bit.
module otpsc_loader #(
	parameter int RST_REL_CYC = `OTPSC_RST_REL_NS / `OTPSC_MCLK_NS
) (
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda,
	output logic             o_sda_oe,
	input  wire logic        i_prog_supply_core,
	input  wire logic        i_prog_supply_high,
	input  wire logic        i_main_supply_ok,
	input  wire logic        i_io_supply_ok,
	input  wire logic        i_power_on_pin,
	input  wire logic        i_seq_done,
	input  wire logic        i_power_good,
	input  wire logic [25:0] i_fuse_rdata,
	output logic [2:0]       o_fuse_bank,
	output logic             o_fuse_wr,
	output logic [25:0]      o_fuse_wdata,
	output logic             o_power_enable,
	output logic             o_processor_reset_n,
	output logic             o_power_on_sense_select,
	output logic             o_voltage_step_rate_select,
	output logic             o_sequence_step_select
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [6:0] sy1_reg, sy2_reg, sy_next;
	logic [2:0] dly_reg;
	logic       scl_s, sda_s, pin_s, core_s, high_s, main_s, io_s;
	assign sy_next = {i_io_supply_ok, i_main_supply_ok, i_prog_supply_high,
		i_prog_supply_core, i_power_on_pin, i_sda, i_scl};
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sy1_reg <= 7'h00;
			sy2_reg <= 7'h00;
			dly_reg <= 3'h0;
		end else begin
			sy1_reg <= sy_next;
			sy2_reg <= sy1_reg;
			dly_reg <= sy2_reg[2:0];
		end
	end
	assign {io_s, main_s, high_s, core_s, pin_s, sda_s, scl_s} = sy2_reg;
	// ----------------------------------------------------------------
	// Fuse ECC and bank map
	// ----------------------------------------------------------------
	function automatic logic [4:0] ecc_syn(input logic [19:0] d);
		int         p, j;
		logic [4:0] s;
		s = 5'h00;
		j = 0;
		for (p = 3; p < 26; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (d[j]) s = s ^ 5'(p);
				j++;
			end
		end
		return s;
	endfunction
	function automatic logic [20:0] ecc_fix(input logic [25:0] f);
		int          p, j;
		logic [4:0]  s;
		logic [19:0] d;
		d = f[19:0];
		s = ecc_syn(f[19:0]) ^ f[24:20];
		j = 0;
		for (p = 3; p < 26; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (^f && s == 5'(p)) d[j] = ~d[j];
				j++;
			end
		end
		return {^f, d};
	endfunction
	function automatic logic [6:0] fidx(input logic [2:0] b,
		input logic [1:0] k);
		if (b == 3'h4) begin
			return (k == 2'h0) ? 7'h40 : (k == 2'h1) ? 7'h48 : 7'h5f;
		end
		return 7'({b, 1'b0} + b + k);
	endfunction
	// ----------------------------------------------------------------
	// Serial slave
	// ----------------------------------------------------------------
	otpsc_pkg::otpsc_i2c_t ist_reg, ist_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] sh8_reg, sh8_next, ptr_reg, ptr_next, rd_byte;
	logic       rw_reg, rw_next, pok_reg, pok_next, oe_reg, oe_next;
	logic       bus_ok, rise, fall, start, stop, wr_stb;
	logic [7:0] sh_reg [0:95];
	logic [7:0] sh_next [0:95];
	logic [7:0] page_reg, page_next, pa_reg, pa_next, pb_reg, pb_next;
	logic [7:0] ecc_reg, ecc_next;
	assign bus_ok = main_s & io_s;
	assign rise   = scl_s & ~dly_reg[0];
	assign fall   = ~scl_s & dly_reg[0];
	assign start  = scl_s & dly_reg[0] & dly_reg[1] & ~sda_s;
	assign stop   = scl_s & dly_reg[0] & ~dly_reg[1] & sda_s;
	assign o_sda  = 1'b0;
	assign o_sda_oe = oe_reg;
	always_comb begin
		rd_byte = 8'h00;
		if (ptr_reg == `OTPSC_REG_PAGE) begin
			rd_byte = page_reg;
		end else if (page_reg == `OTPSC_PAGE_MAIN
			&& ptr_reg == `OTPSC_REG_ECC) begin
			rd_byte = ecc_reg;
		end else if (page_reg == `OTPSC_PAGE_SHADOW
			&& ptr_reg >= `OTPSC_SHADOW_BASE) begin
			rd_byte = sh_reg[7'(ptr_reg - `OTPSC_SHADOW_BASE)];
			if (ptr_reg == `OTPSC_REG_BUSADDR) rd_byte[3] = 1'b1;
		end
	end
	always_comb begin
		ist_next = ist_reg;
		bit_next = bit_reg;
		sh8_next = sh8_reg;
		ptr_next = ptr_reg;
		rw_next  = rw_reg;
		pok_next = pok_reg;
		oe_next  = oe_reg;
		wr_stb   = 1'b0;
		if (!bus_ok || stop) begin
			ist_next = otpsc_pkg::otpsc_i_idle;
			oe_next  = 1'b0;
		end else if (start) begin
			ist_next = otpsc_pkg::otpsc_i_addr;
			bit_next = 4'h0;
			pok_next = 1'b0;
			oe_next  = 1'b0;
		end else begin
			unique case (ist_reg)
				otpsc_pkg::otpsc_i_idle: begin
				end
				otpsc_pkg::otpsc_i_addr, otpsc_pkg::otpsc_i_rx: begin
					if (rise) begin
						sh8_next = {sh8_reg[6:0], sda_s};
						bit_next = bit_reg + 4'h1;
					end else if (fall && bit_reg == 4'h8) begin
						if (ist_reg == otpsc_pkg::otpsc_i_addr) begin
							if (sh8_reg[7:1] == {`OTPSC_ADDR_HIGH,
								sh_reg[95][2:0]}) begin
								ist_next = otpsc_pkg::otpsc_i_acka;
								rw_next  = sh8_reg[0];
								oe_next  = 1'b1;
							end else begin
								ist_next = otpsc_pkg::otpsc_i_idle;
							end
						end else begin
							ist_next = otpsc_pkg::otpsc_i_ackw;
							oe_next  = 1'b1;
							pok_next = 1'b1;
							if (!pok_reg) begin
								ptr_next = sh8_reg;
							end else begin
								wr_stb   = 1'b1;
								ptr_next = ptr_reg + 8'h01;
							end
						end
					end
				end
				otpsc_pkg::otpsc_i_acka, otpsc_pkg::otpsc_i_ackw: begin
					if (fall) begin
						bit_next = 4'h0;
						oe_next  = 1'b0;
						ist_next = otpsc_pkg::otpsc_i_rx;
						if (ist_reg == otpsc_pkg::otpsc_i_acka && rw_reg) begin
							ist_next = otpsc_pkg::otpsc_i_tx;
							sh8_next = rd_byte;
							oe_next  = ~rd_byte[7];
						end
					end
				end
				otpsc_pkg::otpsc_i_tx: begin
					if (rise) begin
						bit_next = bit_reg + 4'h1;
					end else if (fall && bit_reg == 4'h8) begin
						ist_next = otpsc_pkg::otpsc_i_ackr;
						oe_next  = 1'b0;
					end else if (fall) begin
						sh8_next = {sh8_reg[6:0], 1'b0};
						oe_next  = ~sh8_reg[6];
					end
				end
				otpsc_pkg::otpsc_i_ackr: begin
					if (rise && sda_s) begin
						ist_next = otpsc_pkg::otpsc_i_idle;
					end else if (rise) begin
						ptr_next = ptr_reg + 8'h01;
					end else if (fall) begin
						ist_next = otpsc_pkg::otpsc_i_tx;
						bit_next = 4'h0;
						sh8_next = rd_byte;
						oe_next  = ~rd_byte[7];
					end
				end
			endcase
		end
	end
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ist_reg <= otpsc_pkg::otpsc_i_idle;
			bit_reg <= 4'h0;
			sh8_reg <= 8'h00;
			ptr_reg <= 8'h00;
			rw_reg  <= 1'b0;
			pok_reg <= 1'b0;
			oe_reg  <= 1'b0;
		end else begin
			ist_reg <= ist_next;
			bit_reg <= bit_next;
			sh8_reg <= sh8_next;
			ptr_reg <= ptr_next;
			rw_reg  <= rw_next;
			pok_reg <= pok_next;
			oe_reg  <= oe_next;
		end
	end
	// ----------------------------------------------------------------
	// Registers, loader and power-up control
	// ----------------------------------------------------------------
	otpsc_pkg::otpsc_ld_t lst_reg, lst_next;
	logic [2:0]  bank_reg, bank_next, fbk_reg, fbk_next;
	logic        fwr_next, pwr_next, rstn_next, go_reg, go_next;
	logic [25:0] fwd_next;
	logic [19:0] rcnt_reg, rcnt_next, bword;
	logic [20:0] fix;
	logic        try_bit, edge_mode, turn_on, burn_go;
	assign try_bit   = sh_reg[7'h44][`OTPSC_TRY_BIT];
	assign edge_mode = sh_reg[7'h40][`OTPSC_POWER_ON_PIN_BIT];
	assign turn_on   = main_s & pin_s & (~edge_mode | ~dly_reg[2]);
	assign fix       = ecc_fix(i_fuse_rdata);
	assign bword = {sh_reg[fidx(bank_reg, 2'h2)][3:0],
		sh_reg[fidx(bank_reg, 2'h1)], sh_reg[fidx(bank_reg, 2'h0)]};
	assign burn_go = wr_stb && page_reg == `OTPSC_PAGE_PROG
		&& ptr_reg == `OTPSC_REG_BURN && sh8_reg == `OTPSC_BURN_KEY
		&& pa_reg == `OTPSC_PREP_A_KEY && pb_reg == `OTPSC_PREP_B_KEY
		&& high_s;
	always_comb begin
		sh_next   = sh_reg;
		page_next = page_reg;
		pa_next   = pa_reg;
		pb_next   = pb_reg;
		ecc_next  = ecc_reg;
		lst_next  = lst_reg;
		bank_next = bank_reg;
		go_next   = go_reg;
		fwr_next  = 1'b0;
		fwd_next  = o_fuse_wdata;
		pwr_next  = o_power_enable;
		rstn_next = o_processor_reset_n;
		rcnt_next = rcnt_reg;
		if (wr_stb && ptr_reg == `OTPSC_REG_PAGE) page_next = sh8_reg;
		if (wr_stb && page_reg == `OTPSC_PAGE_MAIN
			&& ptr_reg == `OTPSC_REG_ECC)
			ecc_next = ecc_reg & ~sh8_reg;
		if (wr_stb && page_reg == `OTPSC_PAGE_SHADOW
			&& ptr_reg >= `OTPSC_SHADOW_BASE)
			sh_next[7'(ptr_reg - `OTPSC_SHADOW_BASE)] = sh8_reg;
		if (wr_stb && page_reg == `OTPSC_PAGE_PROG) begin
			if (ptr_reg == `OTPSC_REG_PREP_A) pa_next = sh8_reg;
			if (ptr_reg == `OTPSC_REG_PREP_B) pb_next = sh8_reg;
		end
		unique case (lst_reg)
			otpsc_pkg::otpsc_l_pick: begin
				bank_next = 3'h0;
				lst_next  = go_reg ? otpsc_pkg::otpsc_l_on
					: otpsc_pkg::otpsc_l_off;
				if (core_s) begin
					for (int i = 0; i < 96; i++)
						sh_next[i] = (i == 95) ? `OTPSC_ROM_BUSADDR
							: `OTPSC_SHADOW_RESET;
				end else if (!try_bit) begin
					lst_next = otpsc_pkg::otpsc_l_fuse;
				end
			end
			otpsc_pkg::otpsc_l_fuse: begin
				sh_next[fidx(bank_reg, 2'h0)] = fix[7:0];
				sh_next[fidx(bank_reg, 2'h1)] = fix[15:8];
				sh_next[fidx(bank_reg, 2'h2)][3:0] = fix[19:16];
				if (fix[20]) ecc_next[`OTPSC_ECC_BIT] = 1'b1;
				bank_next = bank_reg + 3'h1;
				if (bank_reg == 3'h4) begin
					bank_next = 3'h0;
					lst_next = go_reg ? otpsc_pkg::otpsc_l_on
						: otpsc_pkg::otpsc_l_off;
				end
			end
			otpsc_pkg::otpsc_l_off: begin
				pwr_next  = 1'b0;
				rstn_next = 1'b0;
				rcnt_next = 20'h00000;
				if (burn_go) begin
					lst_next = otpsc_pkg::otpsc_l_burn;
				end else if (turn_on) begin
					go_next  = 1'b1;
					lst_next = otpsc_pkg::otpsc_l_pick;
				end
			end
			otpsc_pkg::otpsc_l_on: begin
				pwr_next = 1'b1;
				if (!main_s || (!edge_mode && !pin_s)
					|| (edge_mode && pin_s && !dly_reg[2])) begin
					go_next  = 1'b0;
					lst_next = otpsc_pkg::otpsc_l_off;
				end else if (burn_go) begin
					lst_next = otpsc_pkg::otpsc_l_burn;
				end else if (i_seq_done && !o_processor_reset_n) begin
					if (sh_reg[7'h48][`OTPSC_PGEN_BIT]) begin
						rstn_next = i_power_good;
					end else if (rcnt_reg == 20'(RST_REL_CYC - 1)) begin
						rstn_next = 1'b1;
					end else begin
						rcnt_next = rcnt_reg + 20'h00001;
					end
				end
			end
			otpsc_pkg::otpsc_l_burn: begin
				fwr_next  = 1'b1;
				fwd_next  = {^{bword, ecc_syn(bword)}, ecc_syn(bword), bword};
				bank_next = bank_reg + 3'h1;
				if (bank_reg == 3'h4) begin
					bank_next = 3'h0;
					lst_next  = go_reg ? otpsc_pkg::otpsc_l_on
						: otpsc_pkg::otpsc_l_off;
				end
			end
		endcase
		// Burn data leaves one cycle late, so its bank index lags too
		fbk_next = (lst_reg == otpsc_pkg::otpsc_l_burn) ? bank_reg
			: bank_next;
	end
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sh_reg              <= '{default: `OTPSC_SHADOW_RESET};
			page_reg            <= `OTPSC_PAGE_MAIN;
			pa_reg              <= 8'h00;
			pb_reg              <= 8'h00;
			ecc_reg             <= 8'h00;
			lst_reg             <= otpsc_pkg::otpsc_l_pick;
			bank_reg            <= 3'h0;
			fbk_reg             <= 3'h0;
			go_reg              <= 1'b0;
			o_fuse_wr           <= 1'b0;
			o_fuse_wdata        <= 26'h0000000;
			o_power_enable      <= 1'b0;
			o_processor_reset_n <= 1'b0;
			rcnt_reg            <= 20'h00000;
		end else begin
			sh_reg              <= sh_next;
			page_reg            <= page_next;
			pa_reg              <= pa_next;
			pb_reg              <= pb_next;
			ecc_reg             <= ecc_next;
			lst_reg             <= lst_next;
			bank_reg            <= bank_next;
			fbk_reg             <= fbk_next;
			go_reg              <= go_next;
			o_fuse_wr           <= fwr_next;
			o_fuse_wdata        <= fwd_next;
			o_power_enable      <= pwr_next;
			o_processor_reset_n <= rstn_next;
			rcnt_reg            <= rcnt_next;
		end
	end
	assign o_fuse_bank                = fbk_reg;
	assign o_power_on_sense_select    = sh_reg[7'h40][`OTPSC_POWER_ON_PIN_BIT];
	assign o_voltage_step_rate_select = sh_reg[7'h40][`OTPSC_DVS_BIT];
	assign o_sequence_step_select     = sh_reg[7'h40][`OTPSC_SEQCLK_BIT];
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	try_write_a: assert property ($rose(try_bit) |-> $past(wr_stb))
		else $error("try bit set without a write");
	rom_load_a: assert property (lst_reg == otpsc_pkg::otpsc_l_pick
		&& core_s |=> sh_reg[95] == `OTPSC_ROM_BUSADDR)
		else $error("rom load missing");
	fuse_pick_a: assert property (lst_reg == otpsc_pkg::otpsc_l_pick
		&& !core_s && !try_bit |=> lst_reg == otpsc_pkg::otpsc_l_fuse)
		else $error("fuse load not started");
	try_keep_a: assert property (lst_reg == otpsc_pkg::otpsc_l_pick
		&& !core_s && try_bit && !wr_stb |=> $stable(sh_reg[0])
		&& lst_reg != otpsc_pkg::otpsc_l_fuse)
		else $error("try mode reloaded shadow");
	burn_key_a: assert property ($rose(o_fuse_wr) |-> $past(pa_reg, 2)
		== `OTPSC_PREP_A_KEY && $past(pb_reg, 2) == `OTPSC_PREP_B_KEY)
		else $error("burn without prepare keys");
	burn_len_a: assert property ($rose(o_fuse_wr) |->
		o_fuse_wr [*5] ##1 !o_fuse_wr)
		else $error("burn not five banks");
	ecc_flag_a: assert property ($rose(ecc_reg[`OTPSC_ECC_BIT]) |->
		$past(lst_reg == otpsc_pkg::otpsc_l_fuse && fix[20]))
		else $error("ecc flag without correction");
	rst_rel_a: assert property ($rose(o_processor_reset_n)
		&& !sh_reg[7'h48][`OTPSC_PGEN_BIT]
		|-> $past(rcnt_reg) == 20'(RST_REL_CYC - 1))
		else $error("reset released early");
	page_keep_a: assert property (!(wr_stb && ptr_reg == `OTPSC_REG_PAGE)
		|=> $stable(page_reg))
		else $error("page changed without write");
	bus_gate_a: assert property (!bus_ok |=>
		ist_reg == otpsc_pkg::otpsc_i_idle && !oe_reg)
		else $error("serial port active without supplies");
	addr_ack_a: assert property ($rose(ist_reg == otpsc_pkg::otpsc_i_acka)
		|-> $past(sh8_reg[7:4]) == `OTPSC_ADDR_HIGH && o_sda_oe)
		else $error("wrong address acknowledged");
	on_main_a: assert property ($rose(o_power_enable) |-> $past(main_s, 2))
		else $error("power on without main supply");
	burn_c: cover property ($rose(o_fuse_wr));
	fix_c: cover property ($rose(ecc_reg[`OTPSC_ECC_BIT]));
	try_c: cover property (lst_reg == otpsc_pkg::otpsc_l_pick && try_bit);
	write_c: cover property (wr_stb);
endmodule

// ### verif/otpsc_master.sv
// Purpose: Serial bus master and supply controller for the loader bench
// Assumes: Data line is open drain, resolved with a pull-up in the bench
// Notes:   Long waits are scaled down to mclk cycles
`timescale 1ns/100ps
module otpsc_master (
	input  wire logic        i_mclk,
	input  wire logic        i_sda,
	output logic             o_scl,
	output logic             o_sda_low,
	output logic             o_prog_core,
	output logic             o_prog_high,
	output logic             o_power_on,
	output logic             o_nack,
	output logic             o_rd_stb,
	output logic [15:0]      o_rd_word
);
	logic [6:0] addr;
	logic       burned;
	initial begin
		{o_scl, o_sda_low, o_prog_core, o_prog_high} = 4'h8;
		{o_power_on, o_nack, o_rd_stb, burned} = 4'h0;
		o_rd_word = 16'h0000;
		addr = 7'h08;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task automatic bitx(input logic b, output logic r);
		o_sda_low = ~b;
		wt(5);
		o_scl = 1'b1;
		wt(5);
		r = i_sda;
		wt(5);
		o_scl = 1'b0;
		wt(5);
	endtask
	task automatic start;
		o_sda_low = 1'b0;
		wt(5);
		o_scl = 1'b1;
		wt(5);
		o_sda_low = 1'b1;
		wt(5);
		o_scl = 1'b0;
		wt(5);
	endtask
	task automatic stop;
		o_sda_low = 1'b1;
		wt(5);
		o_scl = 1'b1;
		wt(5);
		o_sda_low = 1'b0;
		wt(10);
	endtask
	task automatic wr8(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		o_nack = o_nack | r;
	endtask
	task automatic reg_write(input logic [7:0] p, input logic [7:0] d);
		o_nack = 1'b0;
		start;
		wr8({addr, 1'b0});
		wr8(p);
		wr8(d);
		stop;
	endtask
	task automatic reg_read(input logic [7:0] p);
		logic [7:0] b;
		logic       r;
		o_nack = 1'b0;
		start;
		wr8({addr, 1'b0});
		wr8(p);
		start;
		wr8({addr, 1'b1});
		for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
		bitx(1'b1, r);
		stop;
		o_rd_word = {p, b};
		o_rd_stb = 1'b1;
		wt(1);
		o_rd_stb = 1'b0;
	endtask
	task automatic burn_seq;
		if (!burned) begin
			burned = 1'b1;
			reg_write(8'h7f, 8'h02);
			reg_write(8'hd0, 8'hff);
			reg_write(8'hd8, 8'h46);
			o_prog_high = 1'b1;
			wt(50);
			reg_write(8'hd9, 8'hff);
			wt(750);
			o_prog_high = 1'b0;
			wt(500);
		end
	endtask
	task automatic pwr_cycle;
		o_power_on = 1'b0;
		wt(500);
		o_power_on = 1'b1;
		wt(20);
	endtask
endmodule

// ### verif/otpsc_loader_tb_top.sv
// Purpose: Self-checking bench for the start-up configuration loader
// Assumes: Fuse macro modelled as a plain array read by bank index
// Notes:   Reads are queued as expectations and checked by a monitor
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
	err_total++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module otpsc_loader_tb_top;
	logic        clk;
	logic        rst_n;
	logic        main_ok = 1'b1;
	logic        io_ok = 1'b1;
	logic        sda_oe, fuse_wr, pwr_en, rst_out_n;
	logic        sense_sel, step_sel, seq_sel;
	logic [2:0]  fuse_bank;
	logic [25:0] fuse_wdata;
	logic [25:0] fuse [5] = '{default: 26'h0};
	logic [15:0] exp_q [$];
	int          err_total = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          pe_cyc, rs_cyc;
	int          wc [$];
	logic [2:0]  wb [$];
	logic [7:0]  a [3];
	logic [7:0]  b;
	integer      seed = 32'h133f6718;
	wire         scl, sda_low, core, high, pon, rd_stb;
	wire  [15:0] rd_word;
	wire         sda = ~(sda_oe | sda_low);
	wire  [25:0] fuse_rd = (fuse_bank < 3'h5) ? fuse[fuse_bank] : 26'h0;
	otpsc_master m (.i_mclk(clk), .i_sda(sda), .o_scl(scl),
		.o_sda_low(sda_low), .o_prog_core(core), .o_prog_high(high),
		.o_power_on(pon), .o_nack(), .o_rd_stb(rd_stb), .o_rd_word(rd_word));
	otpsc_loader #(.RST_REL_CYC(20)) DUT (.i_mclk(clk), .i_rst_n(rst_n),
		.i_scl(scl), .i_sda(sda), .o_sda(), .o_sda_oe(sda_oe),
		.i_prog_supply_core(core), .i_prog_supply_high(high),
		.i_main_supply_ok(main_ok), .i_io_supply_ok(io_ok),
		.i_power_on_pin(pon), .i_seq_done(pwr_en), .i_power_good(1'b0),
		.i_fuse_rdata(fuse_rd), .o_fuse_bank(fuse_bank), .o_fuse_wr(fuse_wr),
		.o_fuse_wdata(fuse_wdata), .o_power_enable(pwr_en),
		.o_processor_reset_n(rst_out_n),
		.o_power_on_sense_select(sense_sel),
		.o_voltage_step_rate_select(step_sel),
		.o_sequence_step_select(seq_sel));
	// ----------------------------------------------------------------
	// Clock, fuse array and monitors
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (!pwr_en) pe_cyc <= cyc;
		if (!rst_out_n) rs_cyc <= cyc;
		if (fuse_wr) begin
			fuse[fuse_bank] <= fuse_wdata;
			wb.push_back(fuse_bank);
			wc.push_back(cyc);
		end
	end
	always @(posedge rd_stb) begin
		logic [15:0] e;
		e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
		`CHK("read", e, rd_word)
	end
	task automatic complete_run;
		$display("Checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		m.reg_write(p, d);
	endtask
	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		exp_q.push_back({p, e});
		m.reg_read(p);
	endtask
	task automatic wait_hi(input logic rst_sel);
		int n;
		n = 0;
		while ((rst_sel ? rst_out_n : pwr_en) !== 1'b1 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		#1;
		if (n == 1000) begin
			err_total++;
			complete_run;
		end
	endtask
	initial begin
		#400000;
		err_total++;
		complete_run;
	end
	initial begin
		rst_n = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		`CHK("reset outs", 4'h0, {pwr_en, rst_out_n, fuse_wr, sda_oe})
		rst_n = 1'b1;
		m.wt(20);
		`CHK("e0 fields", 3'h0, {sense_sel, step_sel, seq_sel})
		wr(8'h7f, 8'h01);
		rd(8'ha0, 8'h00);
		rd(8'he4, 8'h00);
		rd(8'hff, 8'h08);
		foreach (a[i]) a[i] = 8'($random(seed));
		foreach (a[i]) wr(8'ha0 + 8'(i), a[i]);
		foreach (a[i]) rd(8'ha0 + 8'(i), a[i]);
		wr(8'h7f, 8'h02);
		rd(8'h7f, 8'h02);
		m.burn_seq;
		`CHK("burn count", 5, wb.size())
		foreach (wb[i]) begin
			`CHK("burn bank", 3'(i), wb[i])
			`CHK("burn gap", wc[0] + i, wc[i])
		end
		`CHK("bank0", {a[2][3:0], a[1], a[0]}, fuse[0][19:0])
		wr(8'h7f, 8'h01);
		wr(8'ha0, ~a[0]);
		m.pwr_cycle;
		wait_hi(1'b0);
		wait_hi(1'b1);
		`CHK("release", 1'b1, (rs_cyc - pe_cyc) inside {[19:23]})
		rd(8'ha0, a[0]);
		wr(8'h7f, 8'h00);
		rd(8'h0e, 8'h00);
		fuse[0][3] = ~fuse[0][3];
		m.pwr_cycle;
		wait_hi(1'b0);
		rd(8'h0e, 8'h01);
		wr(8'h0e, 8'h01);
		rd(8'h0e, 8'h00);
		wr(8'h7f, 8'h01);
		rd(8'ha0, a[0]);
		b = 8'($random(seed));
		wr(8'he4, 8'h80);
		wr(8'ha0, b);
		m.pwr_cycle;
		wait_hi(1'b0);
		rd(8'ha0, b);
		io_ok = 1'b0;
		wr(8'ha1, ~a[1]);
		`CHK("nack", 1'b1, m.o_nack)
		io_ok = 1'b1;
		m.wt(10);
		rd(8'ha1, a[1]);
		wr(8'hff, 8'h03);
		m.addr = 7'h0b;
		rd(8'hff, 8'h0b);
		m.o_prog_core = 1'b1;
		m.pwr_cycle;
		wait_hi(1'b0);
		m.addr = 7'h08;
		rd(8'ha0, 8'h00);
		rd(8'hff, 8'h08);
		wr(8'he0, 8'h07);
		`CHK("e0 fields", 3'h7, {sense_sel, step_sel, seq_sel})
		`CHK("queue", 0, exp_q.size())
		complete_run;
	end
endmodule
